// ==== verilog/bstp_top.sv ====
// Boundary-scan test access port sampled by the core clock
`timescale 1ns/10ps
module bstp_top
  import bstp_pkg::*;
(
  input  wire logic i_core_clk,             // Core clock, 100 MHz
  input  wire logic i_reset,                // Synchronous reset, high
  input  wire logic i_ce,                   // Clock enable, freezes state
  input  wire logic i_tck,                  // Test clock pin
  input  wire logic i_tms,                  // Test mode select pin
  input  wire logic i_tdi,                  // Test data in pin
  input  wire logic i_trst_n,               // Test reset pin, low active
  output logic      o_tdo,                  // Test data out level
  output logic      o_tdo_oe_n,             // Data out enable, low drives
  output logic      o_test_logic_reset      // Controller in Test-Logic-Reset
);

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  typedef struct packed {
    bstp_tap_e          tap;                // Controller state
    logic               tck_prev;           // Test clock at last sample
    logic [IR_LEN-1:0]  ir;                 // Active instruction
    logic [IR_LEN-1:0]  ir_sh;              // Instruction shift stage
    logic [DR_LEN-1:0]  dr_sh;              // Data shift stage
    logic               tdo;                // Data out level
    logic               tdo_oe_n;           // Data out enable, low drives
    logic               tlr;                // Test-Logic-Reset flag
  } bstp_state_s;

  localparam bstp_state_s ST_RESET = '{
    tap:      ST_TLR,
    tck_prev: 1'b0,
    ir:       IR_IDCODE,
    ir_sh:    IR_CAPTURE,
    dr_sh:    DR_ZERO,
    tdo:      1'b0,
    tdo_oe_n: 1'b1,
    tlr:      1'b1
  };

  bstp_state_s      st_q;                   // Registered state
  bstp_state_s      st_d;                   // Next state
  logic [SYNC_W-1:0] pins_s;                // Synchronised pins
  logic             tck_s;                  // Test clock, synchronised
  logic             tms_s;                  // Mode select, synchronised
  logic             tdi_s;                  // Data in, synchronised
  logic             trst_n_s;               // Test reset, synchronised
  logic             tck_rise;               // Rising test clock edge
  logic             tck_fall;               // Falling test clock edge
  logic             dr_lsb;                 // Data stage output bit
  logic             ir_lsb;                 // Instruction stage output bit

  // -------------------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------------------
  bstp_sync #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_ce       (i_ce),
    .i_d        ({i_trst_n, i_tdi, i_tms, i_tck}),
    .o_q        (pins_s)
  );

  assign tck_s    = pins_s[SYNC_TCK];
  assign tms_s    = pins_s[SYNC_TMS];
  assign tdi_s    = pins_s[SYNC_TDI];
  assign trst_n_s = pins_s[SYNC_TRST];

  // Edges of the test clock as seen by the core clock
  assign tck_rise = tck_s & ~st_q.tck_prev;
  assign tck_fall = ~tck_s & st_q.tck_prev;
  assign dr_lsb   = st_q.dr_sh[0];
  assign ir_lsb   = st_q.ir_sh[0];

  // -------------------------------------------------------------------------
  // Controller transition table
  // -------------------------------------------------------------------------
  function automatic bstp_tap_e bstp_next(input bstp_tap_e s,
                                          input logic tms);
    bstp_tap_e n;
    n = ST_TLR;
    case (s)
      ST_TLR:    n = tms ? ST_TLR    : ST_RTI;
      ST_RTI:    n = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: n = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: n = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  n = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: n = tms ? ST_UP_DR  : ST_PA_DR;
      ST_PA_DR:  n = tms ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: n = tms ? ST_UP_DR  : ST_SH_DR;
      ST_UP_DR:  n = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: n = tms ? ST_TLR    : ST_CAP_IR;
      ST_CAP_IR: n = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  n = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: n = tms ? ST_UP_IR  : ST_PA_IR;
      ST_PA_IR:  n = tms ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: n = tms ? ST_UP_IR  : ST_SH_IR;
      ST_UP_IR:  n = tms ? ST_SEL_DR : ST_RTI;
      default:   n = ST_TLR;
    endcase
    return n;
  endfunction

  // -------------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    if (i_ce) begin
      st_d.tck_prev = tck_s;
      if (!trst_n_s) begin
        // Test reset wins at once, no test clock edge needed
        st_d.tap      = ST_TLR;
        st_d.ir       = IR_IDCODE;
        st_d.tlr      = 1'b1;
        st_d.tdo_oe_n = 1'b1;
      end else begin
        if (tck_rise) begin
          // Capture and shift act on the state being left
          case (st_q.tap)
            ST_CAP_IR: begin
              st_d.ir_sh = IR_CAPTURE;
            end
            ST_SH_IR: begin
              st_d.ir_sh = {tdi_s, st_q.ir_sh[IR_LEN-1:1]};
            end
            ST_CAP_DR: begin
              // Identity loads its value, others load bypass zero
              st_d.dr_sh = (st_q.ir == IR_IDCODE) ? IDCODE_VAL : DR_ZERO;
            end
            ST_SH_DR: begin
              if (st_q.ir == IR_IDCODE) begin
                st_d.dr_sh = {tdi_s, st_q.dr_sh[DR_LEN-1:1]};
              end else begin
                // Single bypass stage sits in bit 0
                st_d.dr_sh = {DR_ZERO[DR_LEN-1:1], tdi_s};
              end
            end
            default: begin
              st_d.dr_sh = st_q.dr_sh;
            end
          endcase
          // Step the controller on the sampled mode select
          st_d.tap = bstp_next(st_q.tap, tms_s);
          st_d.tlr = (bstp_next(st_q.tap, tms_s) == ST_TLR);
        end
        if (tck_fall) begin
          // Output moves only on falling edges; enable moves on falling edges and is also set high by test reset
          case (st_q.tap)
            ST_SH_IR: begin
              st_d.tdo      = ir_lsb;
              st_d.tdo_oe_n = 1'b0;
            end
            ST_SH_DR: begin
              st_d.tdo      = dr_lsb;
              st_d.tdo_oe_n = 1'b0;
            end
            ST_UP_IR: begin
              st_d.ir       = st_q.ir_sh;
              st_d.tdo_oe_n = 1'b1;
            end
            ST_TLR: begin
              st_d.ir       = IR_IDCODE;
              st_d.tdo_oe_n = 1'b1;
            end
            default: begin
              st_d.tdo_oe_n = 1'b1;
            end
          endcase
        end
      end
    end
  end

  // Register the state; the test clock only acts through its edges
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------
  assign o_tdo              = st_q.tdo;
  assign o_tdo_oe_n         = st_q.tdo_oe_n;
  assign o_test_logic_reset = st_q.tlr;

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);

  // Enabled rising edge with controller live
  sequence s_live_rise;
    i_ce && trst_n_s && tck_rise;
  endsequence

  // Enabled falling edge with controller live
  sequence s_live_fall;
    i_ce && trst_n_s && tck_fall;
  endsequence

  trst_force_a: assert property (
    (i_ce && !trst_n_s) |=> (st_q.tap == ST_TLR) && o_test_logic_reset
                            && o_tdo_oe_n)
    else $error("test reset did not force Test-Logic-Reset");

  tdo_hiz_a: assert property (
    (s_live_fall and (st_q.tap != ST_SH_DR) and (st_q.tap != ST_SH_IR))
      |=> o_tdo_oe_n)
    else $error("data out driven outside shift");

  tdo_dr_fall_a: assert property (
    (s_live_fall and (st_q.tap == ST_SH_DR))
      |=> !o_tdo_oe_n && (o_tdo == $past(dr_lsb)))
    else $error("data out not updated on falling edge");

  tdo_ir_fall_a: assert property (
    (s_live_fall and (st_q.tap == ST_SH_IR))
      |=> !o_tdo_oe_n && (o_tdo == $past(ir_lsb)))
    else $error("instruction bit not shown on falling edge");

  tdo_stable_a: assert property (
    !(i_ce && tck_fall) |=> $stable(o_tdo))
    else $error("data out moved without falling edge");

  ir_shift_a: assert property (
    (s_live_rise and (st_q.tap == ST_SH_IR))
      |=> st_q.ir_sh[IR_LEN-1] == $past(tdi_s))
    else $error("data in not shifted into instruction");

  dr_shift_a: assert property (
    (s_live_rise and (st_q.tap == ST_SH_DR) and (st_q.ir == IR_BYPASS))
      |=> st_q.dr_sh[0] == $past(tdi_s))
    else $error("data in not shifted through bypass");

  tms_step_a: assert property (
    (s_live_rise and (st_q.tap == ST_RTI) and tms_s)
      |=> st_q.tap == ST_SEL_DR)
    else $error("mode select did not leave idle");

  tlr_leave_a: assert property (
    (s_live_rise and (st_q.tap == ST_TLR) and !tms_s)
      |=> (st_q.tap == ST_RTI) && !o_test_logic_reset)
    else $error("controller did not leave reset state");

  no_edge_hold_a: assert property (
    (trst_n_s && !tck_rise) |=> $stable(st_q.tap))
    else $error("controller moved without test clock edge");

endmodule

// ==== include/bstp_pkg.sv ====
// Constants, state encoding and reset values of the boundary-scan port
//
// Notes on behaviour
// - Test data out changes on falling test clock
// - Test data out floats unless shifting
// - Test data in shifts into instruction, data
// - Low test reset forces Test-Logic-Reset at once
// - Scan logic moves only on test clock or low test reset
// - Mode select steers controller state transitions
package bstp_pkg;

  // -------------------------------------------------------------------------
  // Controller states
  // -------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_TLR,       // Test-Logic-Reset
    ST_RTI,       // Run-Test/Idle
    ST_SEL_DR,    // Select-DR-Scan
    ST_CAP_DR,    // Capture-DR
    ST_SH_DR,     // Shift-DR
    ST_EX1_DR,    // Exit1-DR
    ST_PA_DR,     // Pause-DR
    ST_EX2_DR,    // Exit2-DR
    ST_UP_DR,     // Update-DR
    ST_SEL_IR,    // Select-IR-Scan
    ST_CAP_IR,    // Capture-IR
    ST_SH_IR,     // Shift-IR
    ST_EX1_IR,    // Exit1-IR
    ST_PA_IR,     // Pause-IR
    ST_EX2_IR,    // Exit2-IR
    ST_UP_IR      // Update-IR
  } bstp_tap_e;

  // -------------------------------------------------------------------------
  // Register widths and codes
  // -------------------------------------------------------------------------
  localparam int          IR_LEN      = 4;        // Instruction length
  localparam int          DR_LEN      = 32;       // Identity register length
  localparam logic [3:0]  IR_BYPASS   = 4'hf;     // All ones selects bypass
  localparam logic [3:0]  IR_IDCODE   = 4'h1;     // Identity instruction
  localparam logic [3:0]  IR_CAPTURE  = 4'h1;     // Fixed 01 capture pattern
  // Arbitrary neutral identity value, bit 0 set as scan convention demands
  localparam logic [31:0] IDCODE_VAL  = 32'h0a5c_3001;
  localparam logic [31:0] DR_ZERO     = 32'h0000_0000;

  // -------------------------------------------------------------------------
  // Pin synchroniser lanes and their reset levels
  // -------------------------------------------------------------------------
  localparam int          SYNC_W      = 4;        // Lanes through synchroniser
  localparam int          SYNC_TCK    = 0;        // Test clock lane
  localparam int          SYNC_TMS    = 1;        // Mode select lane
  localparam int          SYNC_TDI    = 2;        // Data in lane
  localparam int          SYNC_TRST   = 3;        // Test reset lane
  localparam logic [3:0]  SYNC_RST    = 4'h6;     // Clock and test reset low, mode and data high

endpackage

// ==== verilog/bstp_sync.sv ====
// Two-stage synchroniser for pins arriving from outside the core clock
`timescale 1ns/10ps
module bstp_sync
  import bstp_pkg::*;
#(
  parameter int         W       = 1,        // Number of lanes
  parameter logic [W-1:0] RST_VAL = '0      // Level held through reset
) (
  input  wire logic         i_core_clk,     // Core clock
  input  wire logic         i_reset,        // Synchronous reset, high
  input  wire logic         i_ce,           // Clock enable, freezes state
  input  wire logic [W-1:0] i_d,            // Asynchronous pin levels
  output logic      [W-1:0] o_q             // Levels safe to use
);

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] meta;                     // First stage, second reads it
    logic [W-1:0] safe;                     // Second stage
  } bstp_sync_s;

  bstp_sync_s st_q;                         // Registered state
  bstp_sync_s st_d;                         // Next state

  // Shift pins through both stages
  always_comb begin
    st_d = st_q;
    if (i_ce) begin
      st_d.meta = i_d;
      st_d.safe = st_q.meta;
    end
  end

  // Register the state
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      st_q <= {RST_VAL, RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_q = st_q.safe;

endmodule

// ==== sim/bstp_jtag_host.sv ====
// Behavioural boundary-scan controller that drives the test port pins
`timescale 1ns/10ps
module bstp_jtag_host (
  input  wire logic i_tdo,        // Test data out level from the port
  input  wire logic i_tdo_oe_n,   // Data out enable, low drives
  output logic      o_tck,        // Test clock, still between frames
  output logic      o_tms,        // Mode select
  output logic      o_tdi,        // Test data in
  output logic      o_trst_n      // Test reset, low active
);
  // -------------------------------------------------------------------------
  // Pin level seen by the controller
  // -------------------------------------------------------------------------
  logic last_q = 1'b0;            // Last level the port drove
  logic tdo_pin;                  // Resolved pin level

  // Remember the driven level
  always @(i_tdo or i_tdo_oe_n) begin
    if (!i_tdo_oe_n) begin
      last_q = i_tdo;
    end
  end

  // A floating pin shows the inverse, so a stale bit never matches
  assign tdo_pin = i_tdo_oe_n ? ~last_q : i_tdo;

  // -------------------------------------------------------------------------
  // Power-up: pins idle, test reset pulsed low
  // -------------------------------------------------------------------------
  initial begin
    o_tck    = 1'b0;
    o_tms    = 1'b1;
    o_tdi    = 1'b1;
    o_trst_n = 1'b0;
    #200;
    o_trst_n = 1'b1;
  end

  // Clock n bits; mode and data change only while the clock is low
  task automatic shift(input int n, input logic [63:0] ms,
                       input logic [63:0] di, output logic [63:0] dout,
                       output logic [63:0] oe);
    dout = '0;
    oe   = '1;
    for (int i = 0; i < n; i++) begin
      o_tms = ms[i];
      o_tdi = di[i];
      #31.25;
      o_tck = 1'b1;
      dout[i] = tdo_pin;
      oe[i]   = i_tdo_oe_n;
      #62.5;
      o_tck = 1'b0;
      #31.25;
    end
  endtask

  // Test reset pulse with the test clock standing still
  task automatic pulse_trst();
    o_trst_n = 1'b0;
    #100;
    o_trst_n = 1'b1;
    #50;
  endtask
endmodule

// ==== sim/bstp_top_bench.sv ====
// Self-checking bench for the boundary-scan test port
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  err_count++; $display("Error at %0t: got %h expected %h", \
  $time, (a), (b)); end end
module bstp_top_bench
  import bstp_pkg::*;
;
  // -------------------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------------------
  localparam logic [31:0] PAT = 32'hc3a5_96e1;  // Data pushed in
  logic        core_clk = 1'b0;   // Core clock, 100 MHz
  logic        reset    = 1'b1;   // Synchronous reset
  logic        ce       = 1'b1;   // Clock enable
  logic        tck;               // Test clock
  logic        tms;               // Mode select
  logic        tdi;               // Test data in
  logic        trst_n;            // Test reset
  logic        tdo;               // Test data out
  logic        tdo_oe_n;          // Data out enable
  logic        tlr;               // In Test-Logic-Reset
  logic [63:0] dout;              // Bits seen on the pin
  logic [63:0] oe;                // Enable seen per bit
  int          err_count   = 0;   // Mismatches
  int          check_count = 0;   // Comparisons

  always #5 core_clk = ~core_clk;

  bstp_top bstp_top_inst (
    .i_core_clk        (core_clk),
    .i_reset           (reset),
    .i_ce              (ce),
    .i_tck             (tck),
    .i_tms             (tms),
    .i_tdi             (tdi),
    .i_trst_n          (trst_n),
    .o_tdo             (tdo),
    .o_tdo_oe_n        (tdo_oe_n),
    .o_test_logic_reset(tlr)
  );

  bstp_jtag_host bstp_jtag_host_inst (
    .i_tdo     (tdo),
    .i_tdo_oe_n(tdo_oe_n),
    .o_tck     (tck),
    .o_tms     (tms),
    .o_tdi     (tdi),
    .o_trst_n  (trst_n)
  );

  // -------------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------------
  // Verdict and end of run
  task print_verdict();
    $display("Checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // State after reset and power-up pulse
  task t_reset_state();
    `CHK(tlr, 1'b1)
    `CHK(tdo_oe_n, 1'b1)
  endtask

  // Identity read from Test-Logic-Reset, then data pushed through
  task t_idcode();
    bstp_jtag_host_inst.shift(4, 64'h2, '1, dout, oe);
    bstp_jtag_host_inst.shift(64, 64'h8000_0000_0000_0000,
                              {32'h0, PAT}, dout, oe);
    `CHK(dout[31:0], IDCODE_VAL)
    `CHK(dout[63:32], PAT)
    `CHK(oe, 64'h0)
    `CHK(tlr, 1'b0)
    bstp_jtag_host_inst.shift(2, 64'h1, '1, dout, oe);
    `CHK(oe[1:0], 2'b11)
  endtask

  // Instruction capture, bypass path, five ones back to reset
  task t_ir_bypass();
    bstp_jtag_host_inst.shift(4, 64'h3, '1, dout, oe);
    bstp_jtag_host_inst.shift(4, 64'h8, {60'h0, IR_BYPASS}, dout, oe);
    `CHK(dout[3:0], IR_CAPTURE)
    bstp_jtag_host_inst.shift(4, 64'h3, '1, dout, oe);
    bstp_jtag_host_inst.shift(8, 64'h80, 64'h5a, dout, oe);
    `CHK(dout[7:0], 8'hb4)
    bstp_jtag_host_inst.shift(5, 64'h1f, '1, dout, oe);
    `CHK(tlr, 1'b1)
  endtask

  // Test reset in mid-shift with the test clock still
  task t_trst();
    bstp_jtag_host_inst.shift(5, 64'h6, '1, dout, oe);
    bstp_jtag_host_inst.shift(4, 64'h8, {60'h0, IR_BYPASS}, dout, oe);
    bstp_jtag_host_inst.shift(4, 64'h3, '1, dout, oe);
    bstp_jtag_host_inst.shift(3, 64'h0, 64'h5, dout, oe);
    #500;
    `CHK(tdo_oe_n, 1'b0)
    `CHK(tlr, 1'b0)
    // Enable low freezes everything, test reset included
    @(posedge core_clk);
    #1;
    ce = 1'b0;
    bstp_jtag_host_inst.pulse_trst();
    `CHK(tlr, 1'b0)
    `CHK(tdo_oe_n, 1'b0)
    @(posedge core_clk);
    #1;
    ce = 1'b1;
    #100;
    `CHK(tlr, 1'b0)
    bstp_jtag_host_inst.pulse_trst();
    `CHK(tlr, 1'b1)
    `CHK(tdo_oe_n, 1'b1)
  endtask

  // -------------------------------------------------------------------------
  // Main sequence and watchdog
  // -------------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    reset = 1'b0;
    #300;
    t_reset_state();
    t_idcode();
    t_ir_bypass();
    t_trst();
    t_idcode();
    print_verdict();
  end

  // Whole run needs some 23 us of test clock traffic
  initial begin
    #100000;
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule
